// ### verilog/uwet_map.vh
// Register map and field constants for the wakeup and trigger block
`ifndef UWET_MAP_VH
`define UWET_MAP_VH
`define UWET_ADDR_RESUME 4'h0
`define UWET_ADDR_TRIG 4'h4
`define UWET_ADDR_EP_STATE 4'h8
`define UWET_RESUME_RESET 8'h00
`define UWET_TRIG_RESET 8'h00
`define UWET_BIT_DVR 0
`define UWET_BIT_RWU 1
`define UWET_BIT_SETUP_DONE 0
`define UWET_BIT_CIN_RDY 1
`define UWET_BIT_COUT_DONE 2
`define UWET_BIT_EP3_RDY 3
`define UWET_BIT_EP1_RDY 4
`define UWET_BIT_EP2_DONE 5
`define UWET_RESP_OKAY 2'b00
`define UWET_RESP_SLVERR 2'b10
`endif

// ### verilog/uwet_wakeup.v
// Remote-wakeup status tracking and resume pulse
`default_nettype none
module uwet_wakeup (
  input wire clk_i,
  input wire rst_b_i,
  input wire set_feature_rwu_i,
  input wire clear_feature_rwu_i,
  input wire resume_wr_i,
  input wire suspended_i,
  output reg remote_wakeup_allowed_o,
  output reg device_resume_request_o
);
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      remote_wakeup_allowed_o <= 1'b0;
      device_resume_request_o <= 1'b0;
    end else begin
      // Set_Feature wins if both arrive together
      if (set_feature_rwu_i) begin
        remote_wakeup_allowed_o <= 1'b1;
      end else if (clear_feature_rwu_i) begin
        remote_wakeup_allowed_o <= 1'b0;
      end
      // Pulse only when suspended; clock is assumed running by then
      device_resume_request_o <= resume_wr_i & suspended_i;
    end
  end
endmodule // uwet_wakeup
`default_nettype wire

// ### verilog/uwet_setup_gate.v
// Data-stage NAK gate held after setup until software reads the command
`default_nettype none
module uwet_setup_gate (
  input wire clk_i,
  input wire rst_b_i,
  input wire setup_received_i,
  input wire setup_read_done_i,
  output reg data_stage_nak_o
);
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_stage_nak_o <= 1'b0;
    end else if (setup_received_i) begin
      // New setup re-arms the NAK even in the same cycle as the release
      data_stage_nak_o <= 1'b1;
    end else if (setup_read_done_i) begin
      data_stage_nak_o <= 1'b0;
    end
  end
endmodule // uwet_setup_gate
`default_nettype wire

// ### verilog/uwet_top.v
// AXI4-Lite register block for remote wakeup and endpoint FIFO triggers
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`default_nettype none
`include "uwet_map.vh"
module uwet_top (
  input wire clk_i,
  input wire rst_b_i,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire set_feature_rwu_i,
  input wire clear_feature_rwu_i,
  input wire suspended_i,
  input wire setup_received_i,
  input wire ep1_active_sel_i,
  input wire ep2_active_sel_i,
  output wire remote_wakeup_allowed_o,
  output wire device_resume_request_o,
  output wire data_stage_nak_o,
  output reg [1:0] bulk_in_packet_ready_o,
  output reg [1:0] bulk_out_read_done_o,
  output reg third_in_packet_ready_o,
  output reg control_out_read_done_o,
  output reg control_in_packet_ready_o,
  output reg setup_read_done_o
);
  reg aw_held_q;
  reg [3:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg resume_wr_q;
  wire do_write;
  wire [3:0] wr_addr;
  wire [7:0] wr_byte;
  wire wr_trig;
  wire [7:0] resume_rd;
  wire [7:0] state_rd;

  // Decode used by both write and read paths
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `UWET_ADDR_RESUME) || (a == `UWET_ADDR_TRIG) ||
               (a == `UWET_ADDR_EP_STATE);
    end
  endfunction

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign do_write = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_q || (s_axi_wvalid && s_axi_wready));
  assign wr_byte = w_held_q ? (w_strb_q[0] ? w_data_q[7:0] : 8'h00) :
                   (s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00);
  assign wr_trig = do_write && (wr_addr == `UWET_ADDR_TRIG);

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UWET_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_addr) ? `UWET_RESP_OKAY :
                       `UWET_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Triggers hold no state beyond a single-cycle pulse
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      resume_wr_q <= 1'b0;
      bulk_in_packet_ready_o <= 2'b00;
      bulk_out_read_done_o <= 2'b00;
      third_in_packet_ready_o <= 1'b0;
      control_out_read_done_o <= 1'b0;
      control_in_packet_ready_o <= 1'b0;
      setup_read_done_o <= 1'b0;
    end else begin
      resume_wr_q <= do_write && (wr_addr == `UWET_ADDR_RESUME) &&
                     wr_byte[`UWET_BIT_DVR];
      // Only the currently effective FIFO of each pair gets the pulse
      bulk_out_read_done_o <= (wr_trig && wr_byte[`UWET_BIT_EP2_DONE]) ?
        (ep2_active_sel_i ? 2'b10 : 2'b01) : 2'b00;
      bulk_in_packet_ready_o <= (wr_trig && wr_byte[`UWET_BIT_EP1_RDY]) ?
        (ep1_active_sel_i ? 2'b10 : 2'b01) : 2'b00;
      third_in_packet_ready_o <= wr_trig &&
                                 wr_byte[`UWET_BIT_EP3_RDY];
      control_in_packet_ready_o <= wr_trig &&
                                   wr_byte[`UWET_BIT_CIN_RDY];
      control_out_read_done_o <= wr_trig &&
                                 wr_byte[`UWET_BIT_COUT_DONE];
      setup_read_done_o <= wr_trig &&
                           wr_byte[`UWET_BIT_SETUP_DONE];
    end
  end

  uwet_wakeup u_wakeup (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .set_feature_rwu_i(set_feature_rwu_i),
    .clear_feature_rwu_i(clear_feature_rwu_i),
    .resume_wr_i(resume_wr_q),
    .suspended_i(suspended_i),
    .remote_wakeup_allowed_o(remote_wakeup_allowed_o),
    .device_resume_request_o(device_resume_request_o)
  );

  uwet_setup_gate u_setup_gate (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .setup_received_i(setup_received_i),
    .setup_read_done_i(setup_read_done_o),
    .data_stage_nak_o(data_stage_nak_o)
  );

  // Resume bit 0 and bits 7..2 always read zero
  assign resume_rd = {6'h00, remote_wakeup_allowed_o, 1'b0};
  assign state_rd = {5'h00, data_stage_nak_o, ep2_active_sel_i,
                     ep1_active_sel_i};

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UWET_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `UWET_RESP_OKAY :
                     `UWET_RESP_SLVERR;
      case (s_axi_araddr)
        `UWET_ADDR_RESUME: begin
          s_axi_rdata <= {24'h00_0000, resume_rd};
        end
        `UWET_ADDR_EP_STATE: begin
          s_axi_rdata <= {24'h00_0000, state_rd};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // uwet_top
`default_nettype wire

// ### dv/uwet_host_model.sv
// Host side model: feature and setup requests as one-cycle pulses
`default_nettype none
module uwet_host_model (
  input wire logic clk_i,
  input wire logic [1:0] req_i,
  output logic set_o,
  output logic clr_o,
  output logic setup_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    set_o <= (req_i == 2'h1);
    clr_o <= (req_i == 2'h2);
    setup_o <= (req_i == 2'h3);
  end
endmodule // uwet_host_model
`default_nettype wire

// ### dv/uwet_assertions.sv
// Checker for wakeup status, NAK gate and trigger pulses
`default_nettype none
module uwet_assertions (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic set_feature_rwu_i,
  input wire logic clear_feature_rwu_i,
  input wire logic suspended_i,
  input wire logic setup_received_i,
  input wire logic ep1_active_sel_i,
  input wire logic ep2_active_sel_i,
  input wire logic remote_wakeup_allowed_o,
  input wire logic device_resume_request_o,
  input wire logic data_stage_nak_o,
  input wire logic [1:0] bulk_in_packet_ready_o,
  input wire logic [1:0] bulk_out_read_done_o,
  input wire logic setup_read_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rwu_set: assert property (set_feature_rwu_i |=>
    remote_wakeup_allowed_o) else $error("wakeup not set");
  a_rwu_clear: assert property (clear_feature_rwu_i &&
    !set_feature_rwu_i |=> !remote_wakeup_allowed_o)
    else $error("not cleared");
  a_rwu_hold: assert property (!set_feature_rwu_i &&
    !clear_feature_rwu_i |=> $stable(remote_wakeup_allowed_o))
    else $error("wakeup status moved");
  a_nak_set: assert property (setup_received_i |=>
    data_stage_nak_o) else $error("no NAK after setup");
  a_nak_free: assert property (setup_read_done_o &&
    !setup_received_i ##1 !setup_received_i |-> !data_stage_nak_o)
    else $error("NAK kept");
  a_pulse_one: assert property (setup_read_done_o ||
    device_resume_request_o |=> !setup_read_done_o && !device_resume_request_o)
    else $error("pulse too long");
  a_pair_sel: assert property ((|bulk_in_packet_ready_o) ||
    (|bulk_out_read_done_o) |-> (bulk_in_packet_ready_o | 
    (2'b01 << ep1_active_sel_i)) == (2'b01 << ep1_active_sel_i) &&
    (bulk_out_read_done_o | (2'b01 << ep2_active_sel_i)) ==
    (2'b01 << ep2_active_sel_i)) else $error("wrong FIFO of pair");
  a_resume_gate: assert property (device_resume_request_o |->
    $past(suspended_i)) else $error("resume outside suspend");
  c_resume: cover property (device_resume_request_o);
  c_ep2_hi: cover property (bulk_out_read_done_o[1]);
  c_nak: cover property (data_stage_nak_o ##1 !data_stage_nak_o);
endmodule // uwet_assertions
bind uwet_top uwet_assertions u_chk (.clk_i, .rst_b_i, .set_feature_rwu_i,
  .clear_feature_rwu_i, .suspended_i, .setup_received_i, .ep1_active_sel_i,
  .ep2_active_sel_i, .remote_wakeup_allowed_o, .device_resume_request_o,
  .data_stage_nak_o, .bulk_in_packet_ready_o, .bulk_out_read_done_o,
  .setup_read_done_o);
`default_nettype wire

// ### dv/uwet_top_tb_top.sv
// Bench for the wakeup and trigger register block
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module usb_wakeup_endpoint_triggers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_b_i = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic susp = 0, e1 = 0, e2 = 0;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, r, seed = 32'h7143_3a21;
  logic [1:0] hreq = 0, eb;
  logic [33:0] er;
  logic [8:0] ep;
  int fail_count = 0, tests_run = 0;
  logic [33:0] rq[$];
  logic [8:0] pq[$];
  logic [1:0] bq[$];
  wire awr, wr_, arr, bv, rv, rwu, res, nak, t3, co, ci, sd, sf, cf, sr;
  wire [1:0] bresp, rresp, bi, bo;
  wire [31:0] rdata;
  wire [8:0] pv = {bi, bo, t3, co, ci, sd, res};
  uwet_host_model host_m (.clk_i(clk_i), .req_i(hreq), .set_o(sf), .clr_o(cf),
    .setup_o(sr));
  uwet_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .set_feature_rwu_i(sf), .clear_feature_rwu_i(cf),
    .suspended_i(susp), .setup_received_i(sr), .ep1_active_sel_i(e1),
    .ep2_active_sel_i(e2), .remote_wakeup_allowed_o(rwu),
    .device_resume_request_o(res), .data_stage_nak_o(nak),
    .bulk_in_packet_ready_o(bi), .bulk_out_read_done_o(bo),
    .third_in_packet_ready_o(t3), .control_out_read_done_o(co),
    .control_in_packet_ready_o(ci), .setup_read_done_o(sd));
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [33:0] st(input logic n);
    return {31'h0, n, e2, e1};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] rs);
    bq.push_back(rs);
    @(posedge clk_i);
    {awa, wd, awv, wv, br} <= {a, d, 3'b111};
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
    end while (!bv);
    br <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk_i);
    {ara, arv, rr} <= {a, 2'b11};
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rr <= 0;
  endtask
  task automatic host(input logic [1:0] c);
    @(posedge clk_i);
    hreq <= c;
    @(posedge clk_i);
    hreq <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rv && rr) begin
      er = rq.pop_front();
      `CHK("read", er, {rresp, rdata})
    end
    if (bv && br) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (|pv) begin
      ep = pq.size() ? pq.pop_front() : 9'h0;
      `CHK("pulses", ep, pv)
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1;
    rd(4'h0, 0);
    rd(4'h8, st(0));
    host(1);
    rd(4'h0, 2);
    wr(4'h0, 32'h0000_00ff, 0);
    rd(4'h0, 2);
    // Bench clock never stops, so wakeup always has a running module clock
    susp <= 1;
    pq.push_back(9'h001);
    wr(4'h0, 32'h0000_0001, 0);
    wr(4'h0, 32'h0000_00fe, 0);
    host(2);
    rd(4'h0, 0);
    repeat (16) begin
      r = xs();
      {e2, e1} <= r[9:8];
      if (|r[5:0]) pq.push_back({r[4] & r[8], r[4] & !r[8], r[5] & r[9],
        r[5] & !r[9], r[3:0], 1'b0});
      wr(4'h4, r, 0);
    end
    rd(4'h4, 0);
    host(3);
    rd(4'h8, st(1));
    pq.push_back(9'h002);
    wr(4'h4, 32'h0000_0001, 0);
    rd(4'h8, st(0));
    rd(4'hc, {2'b10, 32'h0});
    wr(4'hc, 32'hffff_ffff, 2'b10);
    repeat (4) @(posedge clk_i);
    `CHK("unmatched", 0, pq.size())
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    wrap_up;
  end
endmodule // usb_wakeup_endpoint_triggers_tb_top
`default_nettype wire
